// >>> src/canmb_pkg.sv
package canmb_pkg;

    // Buffer geometry.
    localparam int TX_NUM    = 3;
    localparam int TX_IW     = 2;
    localparam int BUF_BYTES = 14;
    localparam int ADDR_W    = 12;
    localparam int FIFO_DEPTH = 8;

    // Byte positions inside one message buffer.
    localparam logic [3:0] IDX_ID0  = 4'h0;
    localparam logic [3:0] IDX_ID1  = 4'h1;
    localparam logic [3:0] IDX_PAY0 = 4'h4;
    localparam logic [3:0] IDX_LEN  = 4'hc;
    localparam logic [3:0] IDX_PRIORITY = 4'hd;

    // Field positions inside the identifier and length bytes.
    localparam int ID1_RTR_BIT  = 4;
    localparam int ID1_IDE_BIT  = 3;
    localparam int LEN_CODE_MSB = 3;
    localparam logic [3:0] PAY_MAX = 4'h8;

    // Stream steps: four identifier bytes, then the length byte.
    localparam logic [3:0] STEP_LEN = 4'h4;
    localparam logic [3:0] SHIFT_LAST = 4'h7;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADDR_TXWIN = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_TXEND = 12'h038;
    localparam logic [ADDR_W-1:0] ADDR_TFLG  = 12'h040;
    localparam logic [ADDR_W-1:0] ADDR_TSEL  = 12'h044;
    localparam logic [ADDR_W-1:0] ADDR_RFLG  = 12'h048;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 12'h04c;
    localparam logic [ADDR_W-1:0] ADDR_RXWIN = 12'h080;
    localparam logic [ADDR_W-1:0] ADDR_RXEND = 12'h0b4;
    localparam int STAT_BUSY_BIT = 4;

    // Types.
    typedef logic [BUF_BYTES-1:0][7:0] canmb_buf_t;
    typedef canmb_buf_t [TX_NUM-1:0]   canmb_txarr_t;

    typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_WAIT} canmb_tx_state_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } canmb_byte_t;

    typedef struct packed {
        canmb_txarr_t          txb;
        logic [TX_NUM-1:0]     txe;
        logic [TX_NUM-1:0]     tsel;
        canmb_buf_t            rxb;
        logic                  rx_full;
        logic [3:0]            rx_ptr;
        canmb_tx_state_t       tx_st;
        logic                  tx_busy;
        logic [TX_IW-1:0]      tx_act;
        logic [3:0]            tx_step;
        logic                  ap_wr;
        logic                  ap_rd;
        logic [ADDR_W-1:0]     ap_addr;
        logic [31:0]           hrdata;
        logic                  hready;
        logic [7:0]            sh;
        logic [3:0]            sh_cnt;
        logic                  sh_last;
        logic                  bit_valid;
        logic                  bit_last;
    } canmb_state_t;

    // Values after reset: all transmit buffers empty, bus ready.
    localparam canmb_state_t ST_RST = '{txe: '1, hready: 1'b1,
                                        tx_st: TX_IDLE, default: '0};

endpackage

// >>> src/canmb_top.sv
// Behaviour
// - standard id split byte0 and byte1 7:5.
// - identifier goes out most significant first.
// - smallest identifier wins bus arbitration.
// - byte1 bit 4 is remote flag.
// - byte1 bit 3 selects standard/extended format.
// - eight payload bytes per buffer.
// - length code governs payload byte count.
// - length code bits 3:0, 0..8 direct.
// - remote frame: length sent, no data.
// - per buffer local priority, smaller wins.
// - only non-empty buffers compete before start.
// - lowest priority value wins.
// - ties go to lowest buffer index.
// - priority access only empty and selected.
// - clearing empty flag queues; success sets it.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module canmb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // Filling side.
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Draining side.
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } canmb_fifo_st_t;

    canmb_fifo_st_t st_reg;
    canmb_fifo_st_t st_next;

    // Pointers carry a wrap bit, so depth must be a power of two.
    assign o_in_ready  = !((st_reg.wp[AW] != st_reg.rp[AW]) &&
                           (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]));
    assign o_out_valid = (st_reg.wp != st_reg.rp);
    assign o_out_data  = st_reg.mem[st_reg.rp[AW-1:0]];

    // Push and pop advance their pointers only on a handshake.
    always_comb begin
        st_next = st_reg;
        if (i_in_valid && o_in_ready) begin
            st_next.mem[st_reg.wp[AW-1:0]] = i_in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (o_out_valid && i_out_ready) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////

module canmb_top import canmb_pkg::*; (
    // Clock and reset.
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RSTN,
    // AHB-Lite slave.
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // Transmit bit stream towards the bus logic.
    output logic             O_TX_BIT,
    output logic             O_TX_BIT_VALID,
    output logic             O_TX_LAST_BIT,
    input  wire logic        I_TX_BIT_READY,
    input  wire logic        I_BUS_IDLE,
    input  wire logic        I_TX_ACK,
    input  wire logic        I_TX_ERR,
    output logic             O_TX_BUSY,
    // Receive byte stream from the bus logic.
    input  wire logic        I_RX_VALID,
    input  wire logic        I_RX_FIRST,
    input  wire logic [7:0]  I_RX_BYTE,
    input  wire logic        I_RX_END,
    output logic             O_RX_FULL
);

    canmb_state_t s_reg;
    canmb_state_t s_next;

    logic        fifo_in_valid;
    canmb_byte_t fifo_in_data;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    canmb_byte_t fifo_out_data;
    logic        fifo_out_ready;

    ////////////////////////////////////////////////////////////////////////////

    // Payload byte count from the length byte and the identifier byte 1.
    function automatic logic [3:0] f_pay_count(input logic [7:0] len,
                                               input logic [7:0] id1);
        logic [3:0] code;
        code = len[LEN_CODE_MSB:0];
        if (id1[ID1_RTR_BIT]) begin
            f_pay_count = 4'h0;
        end else if (code > PAY_MAX) begin
            f_pay_count = PAY_MAX;
        end else begin
            f_pay_count = code;
        end
    endfunction

    // Buffer byte carried at a stream step: id bytes, length, payload.
    function automatic logic [3:0] f_step_idx(input logic [3:0] step);
        if (step < STEP_LEN) begin
            f_step_idx = step;
        end else if (step == STEP_LEN) begin
            f_step_idx = IDX_LEN;
        end else begin
            f_step_idx = step - 4'h1;
        end
    endfunction

    // Index of the one-hot selected buffer.
    function automatic logic [TX_IW-1:0] f_sel_idx(
        input logic [TX_NUM-1:0] sel);
        f_sel_idx = '0;
        for (int i = TX_NUM - 1; i >= 0; i--) begin
            if (sel[i]) begin
                f_sel_idx = TX_IW'(i);
            end
        end
    endfunction

    // Pending buffer with the smallest priority byte; ties to lower index.
    function automatic logic [TX_IW-1:0] f_pick(input logic [TX_NUM-1:0] pend,
                                                input canmb_txarr_t b);
        logic             found;
        logic [7:0]       best;
        f_pick = '0;
        found  = 1'b0;
        best   = 8'h00;
        for (int i = 0; i < TX_NUM; i++) begin
            // Strict less-than keeps the lower index on a tie.
            if (pend[i] && (!found || b[i][IDX_PRIORITY] < best)) begin
                found  = 1'b1;
                best   = b[i][IDX_PRIORITY];
                f_pick = TX_IW'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    // Frame stream buffer between the scheduler and the bit shifter.
    canmb_fifo #(
        .WIDTH ($bits(canmb_byte_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK_SYS),
        .i_rstn      (I_RSTN),
        .i_in_valid  (fifo_in_valid),
        .i_in_data   (fifo_in_data),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (fifo_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Next state of the bus slave, the transmit and receive buffers and both stream engines.
    always_comb begin
        logic [3:0]       idx;
        logic [TX_IW-1:0] sidx;
        logic             acc;
        logic [31:0]      rd;
        logic [3:0]       cnt;
        logic [3:0]       ptr;
        logic [3:0]       rcnt;
        logic [TX_NUM-1:0] wsel;
        idx  = s_reg.ap_addr[5:2];
        sidx = f_sel_idx(s_reg.tsel);
        acc  = (|s_reg.tsel) && s_reg.txe[sidx];
        rd   = 32'h0000_0000;
        cnt  = f_pay_count(s_reg.txb[s_reg.tx_act][IDX_LEN],
                           s_reg.txb[s_reg.tx_act][IDX_ID1]);
        ptr  = 4'h0;
        rcnt = 4'h0;
        wsel = '0;
        s_next = s_reg;
        fifo_in_valid = 1'b0;
        fifo_in_data  = '0;
        fifo_out_ready = !s_reg.bit_valid;

        // Read data, decoded during the single wait state.
        if (s_reg.ap_addr < ADDR_TXEND) begin
            if (acc) begin
                rd[7:0] = s_reg.txb[sidx][idx];
            end
        end else if (s_reg.ap_addr == ADDR_TFLG) begin
            rd[TX_NUM-1:0] = s_reg.txe;
        end else if (s_reg.ap_addr == ADDR_TSEL) begin
            rd[TX_NUM-1:0] = s_reg.tsel;
        end else if (s_reg.ap_addr == ADDR_RFLG) begin
            rd[0] = s_reg.rx_full;
        end else if (s_reg.ap_addr == ADDR_STAT) begin
            rd[TX_IW-1:0]     = s_reg.tx_act;
            rd[STAT_BUSY_BIT] = s_reg.tx_busy;
        end else if (s_reg.ap_addr >= ADDR_RXWIN &&
                     s_reg.ap_addr < ADDR_RXEND) begin
            rd[7:0] = s_reg.rxb[idx];
        end

        // Data phase: reads finish after one wait state.
        if (s_reg.ap_rd) begin
            s_next.hrdata = rd;
            s_next.hready = 1'b1;
            s_next.ap_rd  = 1'b0;
        end
        s_next.ap_wr = 1'b0;

        // Data phase of a write; unmapped addresses are ignored.
        if (s_reg.ap_wr) begin
            if (s_reg.ap_addr < ADDR_TXEND) begin
                if (acc) begin
                    s_next.txb[sidx][idx] = I_HWDATA[7:0];
                end
            end else if (s_reg.ap_addr == ADDR_TFLG) begin
                // Writing one clears the empty flag and queues it.
                s_next.txe = s_reg.txe & ~I_HWDATA[TX_NUM-1:0];
            end else if (s_reg.ap_addr == ADDR_TSEL) begin
                wsel = I_HWDATA[TX_NUM-1:0] & s_reg.txe;
                s_next.tsel = wsel & (~wsel + 1'b1);
            end else if (s_reg.ap_addr == ADDR_RFLG) begin
                if (I_HWDATA[0]) begin
                    s_next.rx_full = 1'b0;
                end
            end
        end

        // Address phase: take a transfer when the bus is ready.
        if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
            s_next.ap_addr = I_HADDR[ADDR_W-1:0];
            s_next.ap_wr   = I_HWRITE;
            s_next.ap_rd   = !I_HWRITE;
            s_next.hready  = I_HWRITE;
        end

        // Transmit scheduler.
        case (s_reg.tx_st)
            TX_IDLE: begin
                if (I_BUS_IDLE && (|(~s_reg.txe))) begin
                    s_next.tx_act  = f_pick(~s_reg.txe, s_reg.txb);
                    s_next.tx_step = 4'h0;
                    s_next.tx_st   = TX_LOAD;
                end
            end
            TX_LOAD: begin
                // Bytes in order id0..id3, length, payload; id1 carries
                // the low identifier bits, remote and format flags.
                fifo_in_valid = 1'b1;
                fifo_in_data.data =
                    s_reg.txb[s_reg.tx_act][f_step_idx(s_reg.tx_step)];
                fifo_in_data.last = (s_reg.tx_step == STEP_LEN + cnt);
                if (fifo_in_ready) begin
                    if (fifo_in_data.last) begin
                        s_next.tx_st = TX_WAIT;
                    end else begin
                        s_next.tx_step = s_reg.tx_step + 4'h1;
                    end
                end
            end
            TX_WAIT: begin
                if (I_TX_ACK) begin
                    s_next.txe[s_reg.tx_act] = 1'b1;
                    s_next.tx_st = TX_IDLE;
                end else if (I_TX_ERR) begin
                    // Buffer stays queued and competes again.
                    s_next.tx_st = TX_IDLE;
                end
            end
            default: begin
                s_next.tx_st = TX_IDLE;
            end
        endcase
        s_next.tx_busy = (s_next.tx_st != TX_IDLE);

        // Bit shifter: each byte leaves bit 7 first.
        if (s_reg.bit_valid && I_TX_BIT_READY) begin
            if (s_reg.sh_cnt == 4'h0) begin
                s_next.bit_valid = 1'b0;
            end else begin
                s_next.sh     = {s_reg.sh[6:0], 1'b0};
                s_next.sh_cnt = s_reg.sh_cnt - 4'h1;
            end
        end
        if (fifo_out_valid && !s_reg.bit_valid) begin
            s_next.sh        = fifo_out_data.data;
            s_next.sh_cnt    = SHIFT_LAST;
            s_next.sh_last   = fifo_out_data.last;
            s_next.bit_valid = 1'b1;
        end
        s_next.bit_last = s_next.bit_valid && s_next.sh_last &&
                          (s_next.sh_cnt == 4'h0);

        // Receive capture in the same byte order; dropped while full.
        if (I_RX_VALID) begin
            ptr  = I_RX_FIRST ? 4'h0 : s_reg.rx_ptr;
            rcnt = f_pay_count(s_reg.rxb[IDX_LEN], s_reg.rxb[IDX_ID1]);
            if (!s_reg.rx_full &&
                (ptr <= STEP_LEN || ptr <= STEP_LEN + rcnt)) begin
                s_next.rxb[f_step_idx(ptr)] = I_RX_BYTE;
            end
            if (ptr != 4'hf) begin
                s_next.rx_ptr = ptr + 4'h1;
            end
        end
        // Completion set comes last so it beats a software clear.
        if (I_RX_END) begin
            s_next.rx_full = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register, except the response tied to okay.
    assign O_HRDATA       = s_reg.hrdata;
    assign O_HREADYOUT    = s_reg.hready;
    assign O_HRESP        = 1'b0;
    assign O_TX_BIT       = s_reg.sh[7];
    assign O_TX_BIT_VALID = s_reg.bit_valid;
    assign O_TX_LAST_BIT  = s_reg.bit_last;
    assign O_TX_BUSY      = s_reg.tx_busy;
    assign O_RX_FULL      = s_reg.rx_full;

endmodule

`default_nettype wire

// >>> testbench/canmb_chk.sv
`timescale 1ns/1ps
`default_nettype none

module canmb_chk (
    // Clock, reset and register bus.
    input wire logic       I_CLK_SYS,
    input wire logic       I_RSTN,
    input wire logic       I_HSEL,
    input wire logic [1:0] I_HTRANS,
    input wire logic       I_HWRITE,
    input wire logic       I_HREADY,
    input wire logic       O_HREADYOUT,
    input wire logic       O_HRESP,
    // Link side.
    input wire logic       O_TX_BIT,
    input wire logic       O_TX_BIT_VALID,
    input wire logic       O_TX_LAST_BIT,
    input wire logic       I_TX_BIT_READY,
    input wire logic       I_TX_ACK,
    input wire logic       O_TX_BUSY,
    input wire logic       I_RX_END,
    input wire logic       O_RX_FULL
);
    logic       take;
    logic [7:0] nbit_reg;
    logic [7:0] nbit_next;

    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);

    ////////////////////////////////////////
    // Counts the bits taken so far in the current frame.
    assign take      = O_TX_BIT_VALID && I_TX_BIT_READY;
    assign nbit_next = (take && O_TX_LAST_BIT) ? 8'h00 : nbit_reg + 8'(take);

    // Registers the bit count.
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            nbit_reg <= 8'h00;
        end else begin
            nbit_reg <= nbit_next;
        end
    end

    // A read is answered after exactly one wait cycle.
    sequence s_rd_req;
        I_HSEL && I_HTRANS[1] && !I_HWRITE && I_HREADY;
    endsequence
    sequence s_rd_ans;
        !O_HREADYOUT ##1 O_HREADYOUT;
    endsequence

    AST_RD_WAIT:
    assert property (s_rd_req |=> s_rd_ans)
        else $error("Read not answered after one wait cycle.");
    AST_WR_NOWAIT:
    assert property (I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY
                     |=> O_HREADYOUT)
        else $error("Write was stalled.");
    AST_OKAY:
    assert property (O_HRESP == 1'b0)
        else $error("Response other than okay.");
    AST_BIT_HOLD:
    assert property (O_TX_BIT_VALID && !I_TX_BIT_READY |=> O_TX_BIT_VALID
                     && $stable(O_TX_BIT) && $stable(O_TX_LAST_BIT))
        else $error("Offered bit changed before it was taken.");
    AST_VALID_BUSY:
    assert property (O_TX_BIT_VALID |-> O_TX_BUSY)
        else $error("Bit offered while scheduler idle.");
    AST_START:
    assert property ($rose(O_TX_BUSY) |-> ##[1:6] O_TX_BIT_VALID)
        else $error("Frame start produced no bit.");
    AST_ACK_DONE:
    assert property (O_TX_BUSY && I_TX_ACK && !O_TX_BIT_VALID
                     |-> ##[1:3] !O_TX_BUSY)
        else $error("Scheduler stayed busy after acknowledge.");
    AST_FRAME_LEN:
    assert property (take && O_TX_LAST_BIT |-> nbit_reg[2:0] == 3'h7
                     && nbit_reg >= 8'h27 && nbit_reg <= 8'h67)
        else $error("Frame bit count out of range.");
    AST_RX_FULL:
    assert property (I_RX_END |=> O_RX_FULL)
        else $error("Receive buffer not full after frame end.");
endmodule

bind canmb_top canmb_chk i_chk (.I_CLK_SYS, .I_RSTN, .I_HSEL, .I_HTRANS,
    .I_HWRITE, .I_HREADY, .O_HREADYOUT, .O_HRESP, .O_TX_BIT,
    .O_TX_BIT_VALID, .O_TX_LAST_BIT, .I_TX_BIT_READY, .I_TX_ACK, .O_TX_BUSY,
    .I_RX_END, .O_RX_FULL);

`default_nettype wire

// >>> testbench/canmb_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module canmb_link_model (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Bit stream from the buffer block.
    input  wire logic i_bit,
    input  wire logic i_valid,
    input  wire logic i_last,
    input  wire logic i_slow,
    output logic      o_ready,
    output logic      o_ack
);
    logic q[$];
    int   n_frames;
    logic tog;

    ////////////////////////////////////////
    // A slow link takes a bit only every other cycle.
    assign o_ready = !i_slow || tog;

    // Collects taken bits; the link never loses arbitration.
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tog <= 1'b0;
            o_ack <= 1'b0;
            n_frames <= 0;
        end else begin
            tog <= ~tog;
            o_ack <= i_valid && o_ready && i_last;
            if (o_ack) begin
                n_frames <= n_frames + 1;
            end
            if (i_valid && o_ready) begin
                q.push_back(i_bit);
            end
        end
    end
endmodule

`default_nettype wire

// >>> testbench/canmb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module canmb_top_tb import canmb_pkg::*;;
    logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        slow = 1'b0, bus_idle = 1'b1, err = 1'b0;
    logic        rx_v = 1'b0, rx_f = 1'b0, rx_e = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
    logic [7:0]  rx_b = 8'h00;
    logic [31:0] hrdata;
    logic        hready, hresp, tbit, tval, tlast, tready, ack, busy, rxfull;
    int          n_mismatch = 0;
    int          total_checks = 0;

    canmb_top i_dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .O_TX_BIT(tbit), .O_TX_BIT_VALID(tval), .O_TX_LAST_BIT(tlast),
        .I_TX_BIT_READY(tready), .I_BUS_IDLE(bus_idle), .I_TX_ACK(ack),
        .I_TX_ERR(err), .O_TX_BUSY(busy), .I_RX_VALID(rx_v),
        .I_RX_FIRST(rx_f), .I_RX_BYTE(rx_b), .I_RX_END(rx_e),
        .O_RX_FULL(rxfull));
    canmb_link_model m (.i_clk(clk), .i_rstn(rstn), .i_bit(tbit),
        .i_valid(tval), .i_last(tlast), .i_slow(slow), .o_ready(tready),
        .o_ack(ack));

    ////////////////////////////////////////
    // Free running system clock of 100 ns.
    always #50 clk = ~clk;

    // Compares and counts one value.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t ns: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    // One single bus transfer; waits for ready in both phases.
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        @(posedge clk);
        while (!hready) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hready) @(posedge clk);
        rdat = hrdata;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    // Selects a buffer and fills id0, id1, length, priority and all eight payload bytes.
    task load(input logic [2:0] s, input logic [7:0] i0, i1, len, pr, p0);
        wr(ADDR_TSEL, {29'h0, s});
        wr(12'h000, {24'h0, i0});
        wr(12'h004, {24'h0, i1});
        wr(12'h030, {24'h0, len});
        wr(12'h034, {24'h0, pr});
        for (int i = 0; i < 8; i++) begin
            wr(12'h010 + 12'(4 * i), {24'h0, p0 + 8'(i)});
        end
    endtask

    // Rebuilds the byte that starts at bit k of the captured stream.
    function automatic logic [7:0] get_byte(input int k);
        logic [7:0] v;
        for (int j = 0; j < 8; j++) v = {v[6:0], m.q[k + j]};
        return v;
    endfunction

    task wait_frames(input int n);
        int k;
        k = 0;
        while (m.n_frames < n && k < 4000) begin
            @(posedge clk);
            k++;
        end
        chk(m.n_frames, n);
    endtask

    // Sends one frame from buffer 0 and checks every byte on the link.
    task frame(input logic [7:0] i0, i1, len, p0);
        int base, n, f;
        logic [7:0] e[$];
        base = m.q.size();
        f = m.n_frames;
        n = i1[4] ? 0 : ((len[3:0] > 4'h8) ? 8 : int'(len[3:0]));
        e = {i0, i1, 8'h00, 8'h00, len};
        for (int i = 0; i < n; i++) e.push_back(p0 + 8'(i));
        load(3'h1, i0, i1, len, 8'h7f, p0);
        wr(ADDR_TFLG, 32'h1);
        wait_frames(f + 1);
        chk(m.q.size() - base, 8 * e.size());
        for (int i = 0; i < e.size(); i++) begin
            chk(get_byte(base + 8 * i), e[i]);
        end
        rd(ADDR_TFLG, 32'h7);
    endtask

    // Reset values, read back and the selection gate.
    task t_regs;
        rd(ADDR_TFLG, 32'h7);
        rd(ADDR_STAT, 32'h0);
        rd(12'h100, 32'h0);
        load(3'h1, 8'h5a, 8'he8, 8'h0f, 8'h42, 8'hc0);
        rd(12'h000, 32'h5a);
        rd(12'h004, 32'he8);
        rd(12'h02c, 32'hc7);
        rd(12'h030, 32'h0f);
        rd(12'h034, 32'h42);
        wr(ADDR_TSEL, 32'h0);
        rd(12'h034, 32'h0);
        wr(12'h034, 32'h99);
        wr(ADDR_TSEL, 32'h1);
        rd(12'h034, 32'h42);
    endtask

    // Three queued buffers leave in local priority order.
    task t_priority_field;
        int base, f;
        bus_idle <= 1'b0;
        f = m.n_frames;
        load(3'h1, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00);
        load(3'h2, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00);
        load(3'h4, 8'h03, 8'h00, 8'h00, 8'h01, 8'h00);
        wr(ADDR_TFLG, 32'h7);
        rd(12'h034, 32'h0);
        rd(ADDR_TFLG, 32'h0);
        base = m.q.size();
        bus_idle <= 1'b1;
        wait_frames(f + 3);
        chk(get_byte(base), 8'h02);
        chk(get_byte(base + 40), 8'h03);
        chk(get_byte(base + 80), 8'h01);
    endtask

    // Length codes 0 to 9, a stalling link and remote frames.
    task t_codes;
        for (int c = 0; c < 10; c++) begin
            slow <= c[0];
            frame(8'h10 + 8'(c), 8'h20, 8'(c), 8'h80);
        end
        frame(8'h33, 8'h10, 8'h05, 8'h40);
        frame(8'h34, 8'h18, 8'h08, 8'h40);
    endtask

    // A received data frame is stored up to its count and flagged.
    task t_rx;
        logic [7:0] b[8];
        b = '{8'ha1, 8'h28, 8'h00, 8'h00, 8'h02, 8'h11, 8'h22, 8'h33};
        for (int i = 0; i < 8; i++) begin
            rx_v <= 1'b1;
            rx_f <= (i == 0);
            rx_b <= b[i];
            @(posedge clk);
        end
        rx_v <= 1'b0;
        rx_e <= 1'b1;
        @(posedge clk);
        rx_e <= 1'b0;
        @(posedge clk);
        chk(rxfull, 1'b1);
        rd(ADDR_RXWIN, 32'ha1);
        rd(12'h084, 32'h28);
        rd(12'h094, 32'h22);
        rd(12'h098, 32'h00);
        rd(12'h0b0, 32'h02);
        wr(ADDR_RFLG, 32'h1);
        rd(ADDR_RFLG, 32'h0);
    endtask

    task report_and_stop;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_priority_field;
        t_codes;
        t_rx;
        report_and_stop;
    end

    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule

`default_nettype wire
